//--- design/abg_map.svh
// Purpose: Named constants of the baud generator and autobaud unit
// Assumes: Included by the bare name wherever a constant is needed
// Notes:   Definitions only
`ifndef ABG_MAP_SVH
`define ABG_MAP_SVH

// ============================================================
// Prescaler
`define ABG_FIX_TERM2   2'h1
`define ABG_FIX_TERM3   2'h2
`define ABG_FRAC_HALF   9'h100

// ============================================================
// Oversampling and bit sampling
`define ABG_ASYNC_TERM  4'hf
`define ABG_SYNC_TERM   4'h3
`define ABG_SMP_FIRST   4'h6
`define ABG_SMP_LAST    4'h8
`define ABG_ASYNC_OVS   5'h10
`define ABG_SYNC_OVS    5'h04

// ============================================================
// Autobaud candidates, divide factors in prescaled ticks per bit
`define ABG_NUM_RATES   9
`define ABG_DF0         14'h0030
`define ABG_DF1         14'h0060
`define ABG_DF2         14'h00c0
`define ABG_DF3         14'h0120
`define ABG_DF4         14'h0240
`define ABG_DF5         14'h0480
`define ABG_DF6         14'h0900
`define ABG_DF7         14'h1200
`define ABG_DF8         14'h2400
`define ABG_MEAS_MAX    14'h2880
`define ABG_TOL_SHIFT   3
`define ABG_RLD_SHIFT   4
`define ABG_LAST_BIT    4'h8

// ============================================================
// Expected characters, seven data bits
`define ABG_CH_LA       7'h61
`define ABG_CH_LT       7'h74
`define ABG_CH_UA       7'h41
`define ABG_CH_UT       7'h54

// ============================================================
// Mode field values written on success, and reset values
`define ABG_MODE_7P     3'h3
`define ABG_MODE_8P     3'h7
`define ABG_MODE_8N     3'h1
`define ABG_MODE_RST    3'h0

`endif

//--- design/abg_pkg.sv
// Purpose: Types shared by the baud generator files
// Assumes: Constants live in abg_map.svh
// Notes:   Autobaud states step in Gray code along the usual path
package abg_pkg;
    typedef logic [2:0] abg_mode_t;
    typedef logic [13:0] abg_cnt_t;
    typedef enum logic [2:0] {
        ABG_IDLE  = 3'h0,
        ABG_MEAS  = 3'h1,
        ABG_BYTE1 = 3'h3,
        ABG_GAP   = 3'h2,
        ABG_BYTE2 = 3'h6,
        ABG_DONE  = 3'h7
    } abg_state_t;
endpackage

//--- design/abg_if.sv
// Purpose: Link between the control logic and the prescaler
// Assumes: One clock domain
// Notes:   tick is a one-cycle pulse at the prescaled rate
`timescale 1ns/100ps
`default_nettype none
interface abg_if #(
    parameter int STEP_W = 9
) ();
    logic              fde;
    logic              brs;
    logic              sync;
    logic [STEP_W-1:0] step;
    logic              tick;
    modport ctl (output fde, output brs, output sync, output step, input tick);
    modport div (input fde, input brs, input sync, input step, output tick);
endinterface
`default_nettype wire

//--- design/abg_frac_div.sv
// Purpose: Prescaler giving the baud timer its input tick
// Assumes: Step field is the numerator over 512
// Notes:   Fractional path is used only in asynchronous operation
`timescale 1ns/100ps
`default_nettype none
`include "abg_map.svh"
module abg_frac_div #(
    parameter int STEP_W = 9
) (
    input wire logic clk,
    input wire logic rst_n,
    abg_if.div       bif
);
    import abg_pkg::*;

    // ============================================================
    // Checks
    generate
        if (STEP_W != 9) begin : g_chk
            $error("abg_frac_div: step width must be 9");
        end
    endgenerate

    logic [STEP_W-1:0] acc_r;
    logic [1:0]        fix_r;
    logic              tick_r;

    // ============================================================
    // Decode; the carry of the accumulator is the n/512 rate
    wire [STEP_W:0] sum       = {1'b0, acc_r} + {1'b0, bif.step};
    wire            use_frac  = bif.fde & ~bif.sync;
    wire [1:0]      fix_term  = bif.brs ? `ABG_FIX_TERM3 : `ABG_FIX_TERM2;
    wire            fix_wrap  = fix_r >= fix_term;
    wire            step_zero = (bif.step == '0);

    // Accumulator, fixed divider and registered tick
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_r  <= '0;
            fix_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            acc_r  <= use_frac ? sum[STEP_W-1:0] : acc_r;
            fix_r  <= (use_frac | fix_wrap) ? 2'h0 : fix_r + 2'h1;
            tick_r <= use_frac ? (step_zero | sum[STEP_W]) : fix_wrap;
        end
    end

    assign bif.tick = tick_r;
endmodule
`default_nettype wire

//--- design/abg_top.sv
// Purpose: Baud generator with fractional prescaler and autobaud front end
// Assumes: rxd is asynchronous; all control inputs come from logic on clk
// Notes:   Autobaud times the start bit of the first byte, then samples both
//          bytes at the matched candidate rate to decide case and format
`timescale 1ns/100ps
`default_nettype none
`include "abg_map.svh"
module abg_top #(
    parameter int RLD_W  = 13,
    parameter int STEP_W = 9
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              fractional_divider_enable,
    input  wire logic              prescaler_ratio_select,
    input  wire logic              sync_mode,
    input  wire logic              baud_run,
    input  wire logic [STEP_W-1:0] fraction_step_field,
    input  wire logic              reload_wr,
    input  wire logic [RLD_W-1:0]  reload_wdata,
    input  wire logic              ctrl_wr,
    input  wire abg_pkg::abg_mode_t mode_wdata,
    input  wire logic              odd_wdata,
    input  wire logic              autobaud_enable,
    input  wire logic              autobaud_flag_clr,
    input  wire logic              rxd,
    output logic [RLD_W-1:0]       baud_reload_register_r,
    output logic [RLD_W-1:0]       timer_value_r,
    output abg_pkg::abg_mode_t     frame_mode_field_r,
    output logic                   parity_odd_select_r,
    output logic                   sample_tick_r,
    output logic                   baud_tick_r,
    output logic                   autobaud_busy_r,
    output logic                   autobaud_done_r,
    output logic [3:0]             autobaud_rate_idx_r
);
    import abg_pkg::*;

    // ============================================================
    // Checks: the largest candidate reload needs ten bits
    generate
        if (RLD_W < 10 || RLD_W > 14) begin : g_chk
            $error("abg_top: reload width must be 10 to 14");
        end
    endgenerate

    abg_if #(.STEP_W(STEP_W)) bif ();

    assign bif.fde  = fractional_divider_enable;
    assign bif.brs  = prescaler_ratio_select;
    assign bif.sync = sync_mode;
    assign bif.step = fraction_step_field;

    abg_frac_div #(.STEP_W(STEP_W)) u_div (
        .clk   (clk),
        .rst_n (rst_n),
        .bif   (bif)
    );

    // ============================================================
    // Receive line: three stages, a change counts when stages two and three agree
    logic rx_s1_r, rx_s2_r, rx_s3_r, rx_r, rx_prev_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            {rx_s1_r, rx_s2_r, rx_s3_r, rx_r, rx_prev_r} <= 5'h1f;
        end else begin
            {rx_s1_r, rx_s2_r, rx_s3_r} <= {rxd, rx_s1_r, rx_s2_r};
            rx_r      <= (rx_s2_r == rx_s3_r) ? rx_s3_r : rx_r;
            rx_prev_r <= rx_r;
        end
    end
    wire rx_fall = rx_prev_r & ~rx_r;
    wire rx_rise = ~rx_prev_r & rx_r;

    // ============================================================
    // Autobaud datapath signals
    abg_state_t st_r;
    abg_cnt_t   cnt_r, df_r, hit_df, d_k;
    logic [3:0] bit_r, hit_k;
    logic [8:0] sh_r, byte1_r;
    logic       hit;

    // Candidate divide factors
    function automatic abg_cnt_t df_of(input logic [3:0] k);
        case (k)
            4'h0:    df_of = `ABG_DF0;
            4'h1:    df_of = `ABG_DF1;
            4'h2:    df_of = `ABG_DF2;
            4'h3:    df_of = `ABG_DF3;
            4'h4:    df_of = `ABG_DF4;
            4'h5:    df_of = `ABG_DF5;
            4'h6:    df_of = `ABG_DF6;
            4'h7:    df_of = `ABG_DF7;
            4'h8:    df_of = `ABG_DF8;
            default: df_of = '0;
        endcase
    endfunction

    // Match the start bit width; a 12.5 % window keeps candidates apart
    always_comb begin
        hit    = 1'b0;
        hit_k  = 4'h0;
        hit_df = '0;
        d_k    = '0;
        for (int k = 0; k < `ABG_NUM_RATES; k++) begin
            d_k = df_of(4'(k));
            if (!hit && cnt_r >= d_k - (d_k >> `ABG_TOL_SHIFT)
                     && cnt_r <= d_k + (d_k >> `ABG_TOL_SHIFT)) begin
                hit    = 1'b1;
                hit_k  = 4'(k);
                hit_df = d_k;
            end
        end
    end

    // Frame evaluation over both bytes
    wire [8:0] sh_nxt  = {rx_r, sh_r[8:1]};
    wire [8:0] b1      = byte1_r;
    wire [8:0] b2      = sh_nxt;
    wire       p1      = ^b1[6:0];
    wire       p2      = ^b2[6:0];
    wire       case_ok = (b1[6:0] == `ABG_CH_LA && b2[6:0] == `ABG_CH_LT)
                      || (b1[6:0] == `ABG_CH_UA && b2[6:0] == `ABG_CH_UT);
    wire       stops   = b1[8] & b2[8];
    wire       low7    = ~b1[7] & ~b2[7];
    wire       f7e     = (b1[7] == p1) && (b2[7] == p2) && stops;
    wire       f7o     = (b1[7] != p1) && (b2[7] != p2) && stops;
    wire       f8e     = low7 && (b1[8] == p1) && (b2[8] == p2);
    wire       f8o     = low7 && (b1[8] != p1) && (b2[8] != p2);
    wire       f8n     = low7 && stops;
    wire       fmt_ok  = f7e | f7o | f8e | f8o | f8n;
    wire abg_mode_t ab_mode = (f7e | f7o) ? `ABG_MODE_7P :
                              (f8e | f8o) ? `ABG_MODE_8P : `ABG_MODE_8N;
    wire       ab_odd  = f7o | (~f7e & f8o);
    wire [RLD_W-1:0] ab_rld = RLD_W'((df_r >> `ABG_RLD_SHIFT) - 14'h1);

    // Sample point decode
    wire smp_now = bif.tick && (cnt_r == '0);
    wire last    = smp_now && (bit_r == `ABG_LAST_BIT);
    wire ab_ok   = autobaud_enable && (st_r == ABG_BYTE2) && last && case_ok && fmt_ok;

    // ============================================================
    // Autobaud state machine; every timing step waits on the prescaled tick
    always_ff @(posedge clk) begin
        if (!rst_n || !autobaud_enable) begin
            st_r  <= ABG_IDLE;
            cnt_r <= '0;
            bit_r <= 4'h0;
        end else begin
            case (st_r)
                ABG_IDLE: begin
                    cnt_r <= '0;
                    if (rx_fall) begin
                        st_r <= ABG_MEAS;
                    end
                end
                ABG_MEAS: begin
                    if (rx_rise) begin
                        st_r  <= hit ? ABG_BYTE1 : ABG_IDLE;
                        cnt_r <= hit_df >> 1;
                        bit_r <= 4'h0;
                    end else if (cnt_r > `ABG_MEAS_MAX) begin
                        st_r <= ABG_IDLE;
                    end else if (bif.tick) begin
                        cnt_r <= cnt_r + 14'h1;
                    end
                end
                ABG_BYTE1, ABG_BYTE2: begin
                    if (last) begin
                        st_r <= (st_r == ABG_BYTE1) ? ABG_GAP : (ab_ok ? ABG_DONE : ABG_IDLE);
                    end
                    if (smp_now) begin
                        cnt_r <= df_r - 14'h1;
                        bit_r <= bit_r + 4'h1;
                    end else if (bif.tick) begin
                        cnt_r <= cnt_r - 14'h1;
                    end
                end
                ABG_GAP: begin
                    if (rx_fall) begin
                        st_r  <= ABG_BYTE2;
                        cnt_r <= df_r + (df_r >> 1);
                        bit_r <= 4'h0;
                    end
                end
                ABG_DONE: st_r <= ABG_DONE;
                default:  st_r <= ABG_IDLE;
            endcase
        end
    end

    // Shift register, first byte, matched rate and flags
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sh_r                <= '0;
            byte1_r             <= '0;
            df_r                <= '0;
            autobaud_rate_idx_r <= 4'h0;
            autobaud_busy_r     <= 1'b0;
            autobaud_done_r     <= 1'b0;
        end else begin
            sh_r    <= smp_now ? sh_nxt : sh_r;
            byte1_r <= (st_r == ABG_BYTE1 && last) ? sh_nxt : byte1_r;
            if (st_r == ABG_MEAS && rx_rise && hit) begin
                df_r                <= hit_df;
                autobaud_rate_idx_r <= hit_k;
            end
            autobaud_busy_r <= (st_r != ABG_IDLE) && (st_r != ABG_DONE);
            autobaud_done_r <= ab_ok | (autobaud_done_r & ~autobaud_flag_clr);  // Set wins
        end
    end

    // ============================================================
    // Control bits and reload register; a detection result beats a CPU write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            frame_mode_field_r     <= `ABG_MODE_RST;
            parity_odd_select_r    <= 1'b0;
            baud_reload_register_r <= '0;
        end else if (ab_ok) begin
            frame_mode_field_r     <= ab_mode;
            parity_odd_select_r    <= ab_odd;
            baud_reload_register_r <= ab_rld;
        end else begin
            frame_mode_field_r     <= ctrl_wr ? mode_wdata : frame_mode_field_r;
            parity_odd_select_r    <= ctrl_wr ? odd_wdata : parity_odd_select_r;
            baud_reload_register_r <= reload_wr ? reload_wdata : baud_reload_register_r;
        end
    end

    // ============================================================
    // Baud timer; a load while stopped waits for the run bit
    logic       pend_r;
    logic [3:0] ovs_r;
    wire              ld_req = reload_wr | ab_ok;
    wire [RLD_W-1:0]  ld_val = ab_ok ? ab_rld : reload_wdata;
    wire              uflow  = baud_run && bif.tick && (timer_value_r == '0);
    wire [3:0]        ovs_tm = sync_mode ? `ABG_SYNC_TERM : `ABG_ASYNC_TERM;
    wire              ovs_wr = ovs_r >= ovs_tm;
    wire              in_smp = (ovs_r >= `ABG_SMP_FIRST) && (ovs_r <= `ABG_SMP_LAST);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timer_value_r <= '0;
            pend_r        <= 1'b0;
        end else begin
            pend_r <= (ld_req | pend_r) & ~baud_run;
            if (baud_run && ld_req) begin
                timer_value_r <= ld_val;
            end else if (baud_run && pend_r) begin
                timer_value_r <= baud_reload_register_r;
            end else if (uflow) begin
                timer_value_r <= baud_reload_register_r;
            end else if (baud_run && bif.tick) begin
                timer_value_r <= timer_value_r - 1'b1;
            end
        end
    end

    // Divide underflows by sixteen or four, mark samples seven to nine in asynchronous mode only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ovs_r         <= 4'h0;
            baud_tick_r   <= 1'b0;
            sample_tick_r <= 1'b0;
        end else begin
            ovs_r         <= uflow ? (ovs_wr ? 4'h0 : ovs_r + 4'h1) : ovs_r;
            baud_tick_r   <= uflow & ovs_wr;
            sample_tick_r <= uflow & ~sync_mode & in_smp;
        end
    end

    // ============================================================
    // Helper counting underflows per baud period, for checking only
    logic [4:0] hcnt_r;
    logic       hval_r, sync_q_r;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hcnt_r   <= 5'h00;
            hval_r   <= 1'b0;
            sync_q_r <= 1'b0;
        end else begin
            sync_q_r <= sync_mode;
            hval_r   <= (sync_q_r != sync_mode) ? 1'b0 : (hval_r | baud_tick_r);
            hcnt_r   <= baud_tick_r ? {4'h0, uflow} : hcnt_r + {4'h0, uflow};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    step_zero_a: assert property (fractional_divider_enable && !sync_mode && fraction_step_field == '0 |=> bif.tick) else $error("zero step did not pass clock");
    half_step_a: assert property ((fractional_divider_enable && !sync_mode && fraction_step_field == `ABG_FRAC_HALF)[*3] |-> bif.tick != $past(bif.tick)) else $error("half step rate wrong");
    fixed_third_a: assert property (!(fractional_divider_enable && !sync_mode) && prescaler_ratio_select && bif.tick |=> !bif.tick) else $error("divide by three ticks too close");
    timer_reload_a: assert property (uflow && !ld_req && !pend_r |=> timer_value_r == $past(baud_reload_register_r)) else $error("timer did not reload");
    timer_hold_a: assert property (!baud_run |=> timer_value_r == $past(timer_value_r)) else $error("timer moved while stopped");
    ovs_ratio_a: assert property (baud_tick_r && hval_r && (sync_q_r == sync_mode) |-> hcnt_r == (sync_mode ? `ABG_SYNC_OVS : `ABG_ASYNC_OVS)) else $error("oversample ratio wrong");
    sample_gap_a: assert property (baud_tick_r |-> !sample_tick_r) else $error("sample strobe on period end");
    ab_load_a: assert property (ab_ok |=> baud_reload_register_r == $past(ab_rld) && frame_mode_field_r == $past(ab_mode) && autobaud_done_r) else $error("autobaud result not loaded");
    ab_pair_a: assert property (ab_ok |-> (byte1_r[5] == sh_nxt[5]) && ((byte1_r[6:0] & ~7'h20) == `ABG_CH_UA) && ((sh_nxt[6:0] & ~7'h20) == `ABG_CH_UT)) else $error("autobaud accepted bad pair");
    ab_base_a: assert property ((st_r == ABG_BYTE1 || st_r == ABG_BYTE2) && !bif.tick && autobaud_enable |=> cnt_r == $past(cnt_r)) else $error("autobaud counted off tick");
endmodule
`default_nettype wire

//--- bench/abg_sender.sv
// Purpose: Remote asynchronous sender driving the receive line
// Assumes: Caller gives the bit time in module clocks
// Notes:   Line idles high, so a released line reads as mark
`timescale 1ns/100ps
`default_nettype none
module abg_sender (
    input  wire logic clk,
    output logic      rxd
);
    // ============================================================
    // Line driver
    initial rxd = 1'b1;

    // One character: start, data LSB first, optional parity, stop
    task automatic send_char(input logic [7:0] ch, input int nd, input int par,
                             input int bclk);
        logic [11:0] fr;
        logic        p;
        int          nb;
        fr = 12'h000;
        p = 1'b0;
        for (int i = 0; i < nd; i++) begin
            fr[1+i] = ch[i];
            p = p ^ ch[i];
        end
        nb = 1 + nd;
        // Parity 1 is even, 2 is odd, 0 leaves it out
        if (par != 0) begin
            fr[nb] = (par == 2) ? ~p : p;
            nb++;
        end
        fr[nb] = 1'b1;
        nb++;
        // Bits change at the falling edge, like every other bench input
        for (int i = 0; i < nb; i++) begin
            @(negedge clk);
            rxd = fr[i];
            repeat (bclk - 1) @(negedge clk);
        end
    endtask
endmodule
`default_nettype wire

//--- bench/tb.sv
// Purpose: Self-checking bench for the baud generator and autobaud unit
// Assumes: Inputs change at the falling clock edge
// Notes:   Periods are measured in clocks between baud ticks
`timescale 1ns/100ps
`default_nettype none
module tb;
    import abg_pkg::*;
    logic        clk, rst_n, fde, brs, syn, run, rwr, cwr, odd_w, ab_en, ab_clr;
    logic [8:0]  step;
    logic [12:0] rdata, rld, tmr;
    abg_mode_t   mode_w, mode;
    logic        rxd, odd, stk, btk, busy, done;
    logic [3:0]  idx;
    int          bad_count = 0;
    int          comparisons = 0;
    int          cyc = 0;

    // ============================================================
    // Design and far side
    abg_top DUT (.clk(clk), .rst_n(rst_n), .fractional_divider_enable(fde),
        .prescaler_ratio_select(brs), .sync_mode(syn), .baud_run(run),
        .fraction_step_field(step), .reload_wr(rwr), .reload_wdata(rdata),
        .ctrl_wr(cwr), .mode_wdata(mode_w), .odd_wdata(odd_w),
        .autobaud_enable(ab_en), .autobaud_flag_clr(ab_clr), .rxd(rxd),
        .baud_reload_register_r(rld), .timer_value_r(tmr), .frame_mode_field_r(mode),
        .parity_odd_select_r(odd), .sample_tick_r(stk), .baud_tick_r(btk),
        .autobaud_busy_r(busy), .autobaud_done_r(done), .autobaud_rate_idx_r(idx));
    abg_sender snd (.clk(clk), .rxd(rxd));

    // ============================================================
    // Clock and hang guard; the whole run needs well under 30000 clocks
    initial clk = 1'b0;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            bad_count++;
            wrap_up();
        end
    end

    // ============================================================
    // Shared tasks
    task automatic wrap_up();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Clocks from one baud tick to the next, and sample ticks in between
    task automatic period(output int n, output int s);
        int k;
        k = 0;
        while (btk !== 1'b1 && k < 3000) begin
            @(negedge clk);
            k++;
        end
        n = 0;
        s = 0;
        do begin
            @(negedge clk);
            n++;
            if (stk === 1'b1) s++;
        end while (btk !== 1'b1 && n < 3000);
    endtask

    task automatic presc(input logic f, input logic b, input logic s, input logic [8:0] st);
        @(negedge clk);
        fde = f;
        brs = b;
        syn = s;
        step = st;
    endtask

    // Program prescaler and reload, then time two baud periods
    task automatic rate(input logic f, input logic b, input logic s, input logic [8:0] st,
                        input logic [12:0] r, input int exp);
        int n, sm;
        presc(f, b, s, st);
        rdata = r;
        rwr = 1'b1;
        @(negedge clk);
        rwr = 1'b0;
        check("timer load", 16'(tmr), 16'(r));
        period(n, sm);
        period(n, sm);
        check("period", 16'(n), 16'(exp));
        if (s == 1'b0) check("samples", 16'(sm), 16'd3);
    endtask

    // Send a pair, then compare what the detector wrote
    task automatic autobaud(input logic [7:0] c1, input logic [7:0] c2, input int nd,
                            input int par, input int bclk, input logic ok,
                            input logic [12:0] r, input abg_mode_t m, input logic o,
                            input logic [3:0] ix);
        @(negedge clk);
        cwr = 1'b1;
        mode_w = 3'h5;
        odd_w = 1'b1;
        @(negedge clk);
        cwr = 1'b0;
        ab_en = 1'b1;
        check("ctrl write", 16'(mode), 16'h0005);
        // Two characters back to back; the detector hunts between them
        snd.send_char(c1, nd, par, bclk);
        check("busy in gap", 16'(busy), 16'h0001);
        snd.send_char(c2, nd, par, bclk);
        repeat (8) @(negedge clk);
        check("busy after", 16'(busy), 16'h0000);
        check("done", 16'(done), 16'(ok));
        check("mode", 16'(mode), ok ? 16'(m) : 16'h0005);
        check("odd", 16'(odd), ok ? 16'(o) : 16'h0001);
        if (ok) check("reload", 16'(rld), 16'(r));
        if (ok) check("rate index", 16'(idx), 16'(ix));
        ab_en = 1'b0;
        ab_clr = 1'b1;
        @(negedge clk);
        ab_clr = 1'b0;
        @(negedge clk);
        check("flag clear", 16'(done), 16'h0000);
    endtask

    // ============================================================
    // Main sequence
    initial begin
        {rst_n, fde, brs, syn, run, rwr, cwr, odd_w, ab_en, ab_clr} = 10'h000;
        step = 9'h000;
        rdata = 13'h0000;
        mode_w = 3'h0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        run = 1'b1;
        rate(1'b1, 1'b0, 1'b0, 9'h000, 13'h0003, 64);
        rate(1'b1, 1'b1, 1'b0, 9'h100, 13'h0003, 128);
        rate(1'b1, 1'b0, 1'b0, 9'h180, 13'h0002, 64);
        rate(1'b0, 1'b0, 1'b0, 9'h000, 13'h0002, 96);
        rate(1'b0, 1'b0, 1'b1, 9'h000, 13'h0003, 32);
        rate(1'b1, 1'b1, 1'b1, 9'h000, 13'h0003, 48);
        // A reload written while stopped waits for the run bit
        run = 1'b0;
        rdata = 13'h0007;
        rwr = 1'b1;
        @(negedge clk);
        rwr = 1'b0;
        check("stopped reload", 16'(rld), 16'h0007);
        run = 1'b1;
        @(negedge clk);
        check("deferred load", 16'(tmr), 16'h0007);
        $display("Test rates done");
        // Prescaler first, timer running, then enable
        presc(1'b1, 1'b0, 1'b0, 9'h000);
        autobaud("a", "t", 8, 0, 48, 1'b1, 13'h0002, 3'h1, 1'b0, 4'h0);
        autobaud("A", "T", 7, 1, 96, 1'b1, 13'h0005, 3'h3, 1'b0, 4'h1);
        autobaud("a", "t", 7, 2, 48, 1'b1, 13'h0002, 3'h3, 1'b1, 4'h0);
        autobaud("A", "T", 8, 1, 48, 1'b1, 13'h0002, 3'h7, 1'b0, 4'h0);
        autobaud("a", "T", 8, 0, 48, 1'b0, 13'h0000, 3'h0, 1'b0, 4'h0);
        autobaud("A", "t", 7, 1, 48, 1'b0, 13'h0000, 3'h0, 1'b0, 4'h0);
        presc(1'b1, 1'b0, 1'b0, 9'h100);
        autobaud("A", "T", 8, 0, 96, 1'b1, 13'h0002, 3'h1, 1'b0, 4'h0);
        presc(1'b0, 1'b1, 1'b0, 9'h000);
        autobaud("a", "t", 8, 2, 144, 1'b1, 13'h0002, 3'h7, 1'b1, 4'h0);
        $display("Test autobaud done");
        wrap_up();
    end
endmodule
`default_nettype wire
